// ===== hdl/t2rc_pkg.sv
// shared constants and types for the reload/compare timer
package t2rc_pkg;

    // apb address width in bits
    localparam int unsigned APB_AW = 12;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_CONTROL = 8'hc8;
    localparam logic [7:0] IDX_MODE = 8'hc9;
    localparam logic [7:0] IDX_RC_LOW = 8'hca;
    localparam logic [7:0] IDX_RC_HIGH = 8'hcb;
    localparam logic [7:0] IDX_CNT_LOW = 8'hcc;
    localparam logic [7:0] IDX_CNT_HIGH = 8'hcd;
    localparam logic [7:0] IDX_CAP_CTRL = 8'hd0;
    localparam logic [7:0] IDX_CAP_BASE = 8'hd1;
    localparam logic [7:0] IDX_CAP_LAST = 8'hd6;
    localparam logic [7:0] IDX_IRQ_EN = 8'hd7;

    // control register fields
    localparam int unsigned CTL_FLAG_BIT = 7;
    localparam int unsigned CTL_RUN_BIT = 2;
    localparam int unsigned CTL_MODE_BIT = 0;
    localparam logic [7:0] CTL_MASK = 8'h85;

    // capture control fields
    localparam int unsigned CAP_EN_LSB = 4;
    localparam int unsigned CAP_FLAG_LSB = 0;
    localparam int unsigned CAP_CHANNELS = 3;

    // interrupt enable field
    localparam int unsigned IE_BIT = 0;

    // reset values and the counter's top value
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hffff;

    // prescaler width covers the largest ratio of 512
    localparam int unsigned PRESC_W = 9;
    localparam logic [8:0] PRESC_FULL = 9'h1ff;
    localparam logic [2:0] DIV_TOP = 3'h7;

    // mode register layout, bit 7 down to bit 0
    typedef struct packed {
        logic reload_en;
        logic [2:0] div;
        logic cap_clear;
        logic match_clear;
        logic [1:0] trig;
    } t2rc_mode_t;

    // reload trigger selection
    typedef enum logic [1:0] {
        T2RC_TRIG_OVF,
        T2RC_TRIG_CAP0,
        T2RC_TRIG_CAP1,
        T2RC_TRIG_CAP2
    } t2rc_trig_t;

    // operating mode decoded from mode and reload-enable bits
    typedef enum logic [1:0] {
        T2RC_OP_CAPTURE,
        T2RC_OP_RELOAD,
        T2RC_OP_COMPARE
    } t2rc_op_t;

endpackage

// ===== hdl/t2rc_timer.sv
// 16-bit reload/compare timer with three capture channels behind apb
//
// The implementer's own choice: register access over APB.
`timescale 1ns/100ps
module t2rc_timer
    import t2rc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0] capture_event,
    input wire logic global_irq_enable,
    output logic timer_irq
);

    // true when the word address matches a register index
    function automatic logic addr_is(input logic [APB_AW-1:0] a,
                                     input logic [7:0] idx);
        addr_is = (a == {2'b00, idx, 2'b00});
    endfunction

    // low bits of the divider mask for the selected ratio
    function automatic logic [PRESC_W-1:0] div_mask(input logic [2:0] d);
        div_mask = PRESC_FULL >> (DIV_TOP - d);
    endfunction

    // control register bits
    logic flag;
    logic run;
    logic mode_sel;
    // mode register
    t2rc_mode_t mode;
    // reload/compare pair
    logic [7:0] rc_low;
    logic [7:0] rc_high;
    // counter and prescaler
    logic [15:0] count;
    logic [15:0] next_count;
    logic [PRESC_W-1:0] presc;
    // capture state
    logic [2:0] cap_en;
    logic [2:0] cap_flag;
    logic [15:0] cap [CAP_CHANNELS];
    // timer interrupt enable
    logic timer_ie;

    // apb phase decode
    wire setup_rd = psel & ~penable & ~pwrite;
    wire access = psel & penable;
    wire acc_wr = access & pwrite;

    // per register hit
    wire hit_ctl = addr_is(paddr, IDX_CONTROL);
    wire hit_mode = addr_is(paddr, IDX_MODE);
    wire hit_rcl = addr_is(paddr, IDX_RC_LOW);
    wire hit_rch = addr_is(paddr, IDX_RC_HIGH);
    wire hit_cl = addr_is(paddr, IDX_CNT_LOW);
    wire hit_ch = addr_is(paddr, IDX_CNT_HIGH);
    wire hit_capc = addr_is(paddr, IDX_CAP_CTRL);
    wire hit_ie = addr_is(paddr, IDX_IRQ_EN);
    // capture result registers occupy a contiguous word range
    wire hit_cap = (paddr[1:0] == 2'b00) && (paddr[APB_AW-1:10] == 2'b00)
        && (paddr[9:2] >= IDX_CAP_BASE) && (paddr[9:2] <= IDX_CAP_LAST);
    wire hit_any = hit_ctl | hit_mode | hit_rcl | hit_rch | hit_cl
        | hit_ch | hit_capc | hit_ie | hit_cap;

    // write strobes, effective on the access edge
    wire wr_ctl = acc_wr & hit_ctl;
    wire wr_mode = acc_wr & hit_mode;
    wire wr_rcl = acc_wr & hit_rcl;
    wire wr_rch = acc_wr & hit_rch;
    wire wr_cl = acc_wr & hit_cl;
    wire wr_ch = acc_wr & hit_ch;
    wire wr_capc = acc_wr & hit_capc;
    wire wr_ie = acc_wr & hit_ie;
    wire cnt_wr = wr_cl | wr_ch;

    // zero wait states; unmapped words answer with an error
    assign pready = 1'b1;
    assign pslverr = access & ~hit_any;

    // operating mode selection
    wire t2rc_op_t op = mode_sel ? T2RC_OP_COMPARE :
        (mode.reload_en ? T2RC_OP_RELOAD : T2RC_OP_CAPTURE);

    // the reload pair seen as one 16-bit value
    wire [15:0] rc_value = {rc_high, rc_low};

    // divider tick: all mask bits of the prescaler set
    wire [PRESC_W-1:0] mask = div_mask(mode.div);
    wire tick = run && ((presc | ~mask) == PRESC_FULL);

    // counter events
    wire overflow = tick && (count == CNT_MAX);
    wire match = (op == T2RC_OP_COMPARE) && tick
        && (count == rc_value);

    // enabled capture channels that fire now
    wire [2:0] ev_cap = capture_event & cap_en;
    wire any_cap = |ev_cap;

    // selected reload trigger
    wire t2rc_trig_t trig = t2rc_trig_t'(mode.trig);
    logic trig_hit;
    always_comb begin
        unique case (trig)
            T2RC_TRIG_OVF: trig_hit = overflow;
            T2RC_TRIG_CAP0: trig_hit = ev_cap[0];
            T2RC_TRIG_CAP1: trig_hit = ev_cap[1];
            T2RC_TRIG_CAP2: trig_hit = ev_cap[2];
        endcase
    end

    // reload only in auto-reload mode with reload enabled
    wire reload = (op == T2RC_OP_RELOAD) && trig_hit;
    // automatic clears after capture or match
    wire clear = (mode.cap_clear && any_cap)
        || (mode.match_clear && match);

    // counter next value: software write, reload, clear, count
    always_comb begin
        next_count = count;
        if (cnt_wr) begin
            // software access goes byte by byte
            if (wr_cl) begin
                next_count[7:0] = pwdata[7:0];
            end
            if (wr_ch) begin
                next_count[15:8] = pwdata[7:0];
            end
        end else if (reload) begin
            next_count = rc_value;
        end else if (clear) begin
            next_count = CNT_ZERO;
        end else if (tick) begin
            // carry from low byte into high byte, wraps at ffff
            next_count = count + 16'h0001;
        end
    end

    // counter register; while run is low only software writes, capture reloads and capture clears move it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= CNT_ZERO;
        end else begin
            count <= next_count;
        end
    end

    // prescaler runs only with the timer and restarts per tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc <= '0;
        end else if (!run || tick) begin
            presc <= '0;
        end else begin
            presc <= presc + 9'h001;
        end
    end

    // control register; hardware set wins over software clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag <= 1'b0;
            run <= 1'b0;
            mode_sel <= 1'b0;
        end else begin
            if (overflow || match) begin
                flag <= 1'b1;
            end else if (wr_ctl) begin
                flag <= pwdata[CTL_FLAG_BIT];
            end
            if (wr_ctl) begin
                run <= pwdata[CTL_RUN_BIT];
                mode_sel <= pwdata[CTL_MODE_BIT];
            end
        end
    end

    // mode, reload pair and interrupt enable registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode <= t2rc_mode_t'(RST_BYTE);
            rc_low <= RST_BYTE;
            rc_high <= RST_BYTE;
            timer_ie <= 1'b0;
        end else begin
            if (wr_mode) begin
                mode <= t2rc_mode_t'(pwdata[7:0]);
            end
            if (wr_rcl) begin
                rc_low <= pwdata[7:0];
            end
            if (wr_rch) begin
                rc_high <= pwdata[7:0];
            end
            if (wr_ie) begin
                timer_ie <= pwdata[IE_BIT];
            end
        end
    end

    // capture enables and sticky capture flags, set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_en <= 3'h0;
            cap_flag <= 3'h0;
        end else begin
            if (wr_capc) begin
                cap_en <= pwdata[CAP_EN_LSB +: 3];
                cap_flag <= pwdata[CAP_FLAG_LSB +: 3] | ev_cap;
            end else begin
                cap_flag <= cap_flag | ev_cap;
            end
        end
    end

    // capture result registers take the running count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < CAP_CHANNELS; i++) begin
                cap[i] <= CNT_ZERO;
            end
        end else begin
            for (int i = 0; i < CAP_CHANNELS; i++) begin
                if (ev_cap[i]) begin
                    cap[i] <= count;
                end
            end
        end
    end

    // interrupt request from flag and both enables
    assign timer_irq = flag && timer_ie && global_irq_enable;

    // capture word offset: low then high byte per channel
    wire [7:0] cap_off = paddr[9:2] - IDX_CAP_BASE;
    wire [1:0] cap_ch = cap_off[2:1];
    wire [15:0] cap_sel = (cap_ch == 2'd0) ? cap[0]
        : ((cap_ch == 2'd1) ? cap[1] : cap[2]);

    // read data selection
    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = RST_BYTE;
        if (hit_ctl) begin
            rd_byte = {flag, 4'h0, run, 1'b0, mode_sel};
        end else if (hit_mode) begin
            rd_byte = mode;
        end else if (hit_rcl) begin
            rd_byte = rc_low;
        end else if (hit_rch) begin
            rd_byte = rc_high;
        end else if (hit_cl) begin
            rd_byte = count[7:0];
        end else if (hit_ch) begin
            rd_byte = count[15:8];
        end else if (hit_capc) begin
            rd_byte = {1'b0, cap_en, 1'b0, cap_flag};
        end else if (hit_cap) begin
            rd_byte = cap_off[0] ? cap_sel[15:8] : cap_sel[7:0];
        end else if (hit_ie) begin
            rd_byte = {7'h00, timer_ie};
        end
    end

    // read data is latched in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup_rd) begin
            prdata <= {24'h00_0000, rd_byte};
        end
    end

    // flag rises after overflow or match
    flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        (overflow || match) |=> flag)
        else $error("flag not set by overflow or match");

    // flag stays unless software writes the control register
    flag_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (flag && !wr_ctl) |=> flag)
        else $error("flag cleared without a write");

    // interrupt follows flag and both enables
    irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        (overflow && timer_ie && global_irq_enable && !wr_ie) ##1 global_irq_enable |-> timer_irq)
        else $error("timer interrupt missing");

    // stopped counter keeps its value
    stop_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!run && !cnt_wr && !reload && !clear) |=> $stable(count))
        else $error("count moved while stopped");

    // divide by four gives a tick every fourth cycle
    div_four_a: assert property (@(posedge pclk) disable iff (!presetn)
        (tick && mode.div == 3'd0 && !wr_mode && !wr_ctl)
        ##1 (run && mode.div == 3'd0 && !wr_mode && !wr_ctl) [*3] |=> tick)
        else $error("divide by four tick spacing wrong");

    // plain tick increments by one
    count_inc_a: assert property (@(posedge pclk) disable iff (!presetn)
        (tick && !reload && !clear && !cnt_wr) |=> count == $past(count) + 16'h0001)
        else $error("count did not increment");

    // reload copies the reload pair
    reload_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
        (reload && !cnt_wr) |=> count == $past(rc_value))
        else $error("reload value not loaded");

    // automatic clear zeroes the count
    auto_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        (clear && !reload && !cnt_wr) |=> count == CNT_ZERO)
        else $error("count not cleared");

    // capture stores the count seen at the event
    cap_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
        ev_cap[0] |=> (cap[0] == $past(count)) && cap_flag[0])
        else $error("capture 0 not stored");

    // overflow wraps to zero without reload
    wrap_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        (overflow && !reload && !cnt_wr) |=> count == CNT_ZERO)
        else $error("overflow did not wrap");

endmodule

// ===== verification/tb_top.sv
// self-checking bench for the reload/compare timer
`timescale 1ns/100ps
module tb_top
    import t2rc_pkg::*;
;
    logic pclk = 1'b0; // bus clock
    logic presetn = 1'b0; // async reset
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [APB_AW-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [2:0] capture_event = 3'h0; // capture pulses
    logic global_irq_enable = 1'b0;
    logic timer_irq;
    int bad_count = 0;
    int checks_done = 0;
    logic [7:0] rdat; // last read byte
    logic rerr; // last slave error
    logic [15:0] cnt; // last 16-bit read
    logic [7:0] ctl_seen; // control read while running

    // 100 MHz clock
    always #5 pclk = ~pclk;

    t2rc_timer dut (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .capture_event(capture_event),
        .global_irq_enable(global_irq_enable),
        .timer_irq(timer_irq)
    );

    // compare a byte
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // compare a 16-bit value
    task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // compare a single bit
    task automatic chk1(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask

    // one apb transfer; idles one cycle after so strobes never double up
    task automatic xfer(input logic [7:0] idx, input logic w, input logic [7:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        // wait for the slave; only the watchdog ends a stuck wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat = prdata[7:0];
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        xfer(idx, 1'b1, d);
    endtask

    task automatic rd(input logic [7:0] idx);
        xfer(idx, 1'b0, 8'h00);
    endtask

    // read a byte pair, low index first
    task automatic rd16(input logic [7:0] idx);
        rd(idx);
        cnt[7:0] = rdat;
        rd(idx + 8'h01);
        cnt[15:8] = rdat;
    endtask

    // write a byte pair, low index first
    task automatic wr16(input logic [7:0] idx, input logic [15:0] v);
        wr(idx, v[7:0]);
        wr(idx + 8'h01, v[15:8]);
    endtask

    // run k*p cycles plus six bus cycles, peek control mid-run, stop keeping the flag
    task automatic run_span(input logic [7:0] ctl, input int k, input int p);
        wr(IDX_CONTROL, ctl | 8'h04);
        repeat (k * p) @(posedge pclk);
        rd(IDX_CONTROL);
        ctl_seen = rdat;
        wr(IDX_CONTROL, ctl_seen & 8'hfb);
    endtask

    // one-cycle capture pulse on a channel
    task automatic pulse(input int ch);
        capture_event <= 3'h1 << ch;
        @(posedge pclk);
        capture_event <= 3'h0;
        @(posedge pclk);
    endtask

    // reset values, reserved bits, unmapped address
    task automatic t_reset;
        logic [7:0] idxs[9] = '{8'hc8, 8'hc9, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'hd0, 8'hd1, 8'hd7};
        foreach (idxs[i]) begin
            rd(idxs[i]);
            chk8("reset value", 8'h00, rdat);
        end
        chk1("mapped error", 1'b0, rerr);
        rd(8'h00);
        chk1("unmapped error", 1'b1, rerr);
        chk8("unmapped read", 8'h00, rdat);
        wr(IDX_CONTROL, 8'h7a);
        rd(IDX_CONTROL);
        chk8("control reserved", 8'h00, rdat);
        wr(IDX_MODE, 8'ha5);
        rd(IDX_MODE);
        chk8("mode readback", 8'ha5, rdat);
        $display("test reset done");
    endtask

    // every divider code, carry into high byte, stopped count holds
    task automatic t_div;
        for (int d = 0; d < 8; d++) begin
            wr(IDX_MODE, {1'b0, 3'(d), 4'h0});
            wr16(IDX_CNT_LOW, 16'h00fe);
            run_span(8'h00, 2, 4 << d);
            chk8("run control", 8'h04, ctl_seen);
            rd16(IDX_CNT_LOW);
            chk16("divided count", (d == 0) ? 16'h0101 : 16'h0100, cnt);
        end
        repeat (600) @(posedge pclk);
        rd16(IDX_CNT_LOW);
        chk16("held count", 16'h0100, cnt);
        $display("test divider done");
    endtask

    // overflow wrap, reload on overflow, none in compare mode, irq
    task automatic t_ovf;
        logic [7:0] modes[3] = '{8'h10, 8'h90, 8'h90};
        logic [7:0] ctls[3] = '{8'h00, 8'h00, 8'h01};
        logic [15:0] exps[3] = '{16'h0000, 16'h1234, 16'h0000};
        wr16(IDX_RC_LOW, 16'h1234);
        wr(IDX_IRQ_EN, 8'h01);
        global_irq_enable <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            wr(IDX_MODE, modes[i]);
            wr16(IDX_CNT_LOW, 16'hffff);
            run_span(ctls[i], 1, 8);
            chk1("overflow flag", 1'b1, ctl_seen[7]);
            rd16(IDX_CNT_LOW);
            chk16("after overflow", exps[i], cnt);
            chk1("irq raised", 1'b1, timer_irq);
            global_irq_enable <= 1'b0;
            @(posedge pclk);
            chk1("irq global off", 1'b0, timer_irq);
            global_irq_enable <= 1'b1;
            wr(IDX_CONTROL, 8'h00);
            rd(IDX_CONTROL);
            chk8("flag cleared", 8'h00, rdat);
            chk1("irq cleared", 1'b0, timer_irq);
        end
        wr(IDX_IRQ_EN, 8'h00);
        wr(IDX_CONTROL, 8'h80);
        chk1("irq enable off", 1'b0, timer_irq);
        wr(IDX_IRQ_EN, 8'h01);
        chk1("irq enable on", 1'b1, timer_irq);
        wr(IDX_CONTROL, 8'h00);
        $display("test overflow done");
    endtask

    // compare match with and without auto-clear, and outside compare mode
    task automatic t_cmp;
        logic [7:0] modes[3] = '{8'h14, 8'h10, 8'h10};
        logic [7:0] ctls[3] = '{8'h01, 8'h01, 8'h00};
        logic [15:0] exps[3] = '{16'h0000, 16'h0006, 16'h0006};
        logic flags[3] = '{1'b1, 1'b1, 1'b0};
        wr16(IDX_RC_LOW, 16'h0005);
        for (int i = 0; i < 3; i++) begin
            wr(IDX_MODE, modes[i]);
            wr16(IDX_CNT_LOW, 16'h0003);
            run_span(ctls[i], 3, 8);
            chk1("match flag", flags[i], ctl_seen[7]);
            rd16(IDX_CNT_LOW);
            chk16("after match", exps[i], cnt);
        end
        wr(IDX_CONTROL, 8'h00);
        $display("test compare done");
    endtask

    // reload on each capture trigger, capture clear, disabled channel
    task automatic t_cap;
        int oth;
        wr16(IDX_RC_LOW, 16'h1234);
        for (int i = 1; i < 4; i++) begin
            oth = i % 3;
            wr(IDX_MODE, 8'hf0 | 8'(i));
            wr16(IDX_CNT_LOW, 16'h0050);
            wr(IDX_CAP_CTRL, 8'h70);
            wr(IDX_CONTROL, 8'h04);
            pulse(oth);
            rd16(IDX_CNT_LOW);
            chk16("no reload", 16'h0050, cnt);
            rd16(IDX_CAP_BASE + 8'(2 * oth));
            chk16("other capture", 16'h0050, cnt);
            pulse(i - 1);
            rd16(IDX_CNT_LOW);
            chk16("capture reload", 16'h1234, cnt);
            rd16(IDX_CAP_BASE + 8'(2 * (i - 1)));
            chk16("selected capture", 16'h0050, cnt);
            rd(IDX_CAP_CTRL);
            chk8("capture flags", 8'h70 | (8'h01 << oth) | (8'h01 << (i - 1)), rdat);
            wr(IDX_CONTROL, 8'h00);
        end
        wr(IDX_MODE, 8'h78);
        wr16(IDX_CNT_LOW, 16'h0077);
        wr(IDX_CONTROL, 8'h04);
        pulse(2);
        rd16(IDX_CAP_BASE + 8'h04);
        chk16("clear capture", 16'h0077, cnt);
        rd16(IDX_CNT_LOW);
        chk16("cleared count", 16'h0000, cnt);
        wr(IDX_CAP_CTRL, 8'h00);
        pulse(1);
        rd16(IDX_CAP_BASE + 8'h02);
        chk16("disabled capture", 16'h0050, cnt);
        rd(IDX_CAP_CTRL);
        chk8("disabled flags", 8'h00, rdat);
        wr(IDX_CONTROL, 8'h00);
        $display("test capture done");
    endtask

    // verdict and end of run
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset;
        t_div;
        t_ovf;
        t_cmp;
        t_cap;
        conclude;
    end

    // watchdog, well past the expected few thousand cycles
    initial begin
        #300us;
        bad_count++;
        conclude;
    end
endmodule
